// File: verilog/shs_pkg.sv
// package for the system health supervisor: constants and carrier types
`default_nettype none
package shs_pkg;
  // lockup timer width and default reload count
  localparam int unsigned SHS_TMR_W         = 16;
  localparam logic [15:0] SHS_TMR_RELOAD_RST = 16'hFFFF;
  // first fetch watch window in cycles (kept short enough for a sim by parameter)
  localparam int unsigned SHS_FETCH_WAIT    = 32'h0001_0000;
  // reboot pulse length in cycles
  localparam logic [3:0]  SHS_RST_PULSE     = 4'hF;
  // number of disableable functions
  localparam int unsigned SHS_NFUNC         = 7;
  // function index: lan usb lpc audio sata pcie smbus
  localparam int unsigned SHS_F_LAN = 0;
  localparam int unsigned SHS_F_SMB = 6;
  // error message class codes
  typedef enum logic [1:0] {SHS_ERR_SMI, SHS_ERR_NMI, SHS_ERR_SYSTEM_ERROR_N, SHS_ERR_TMR} shs_err_cls_t;
  // intrusion routing select
  localparam logic SHS_INTR_TO_SMI = 1'b0;
  // per-function decode and event carrier
  typedef struct packed {
    logic [6:0] decode;
    logic [6:0] event_irq;
  } shs_func_t;
endpackage : shs_pkg
`default_nettype wire

// File: verilog/shs_supervisor.sv
// system health supervisor: lockup timer, first fetch check, error routing, function disable, intrusion
// How it works
// - the first expiry of the lockup timer pulses the system-management interrupt.
// - a second expiry with no reload in between starts a full system reset pulse.
// - after reset the block waits for the first fetch and reboots if it never comes in time.
// - an error message from the memory controller raises the interrupt class that it selects.
// - each integrated function has its own disable input.
// - a disabled function's decode claim is forced off.
// - a disabled function's interrupt events are blocked.
// - an active intrusion raises either the system-management or the lockup-timer interrupt, by a select.
`timescale 1ns/1ps
`default_nettype none
module shs_supervisor
  import shs_pkg::*;
#(
  parameter int unsigned FETCH_WAIT = SHS_FETCH_WAIT
)(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // lockup timer control
  input  wire logic              tmr_enable_in,
  input  wire logic [15:0]       tmr_reload_val_in,
  input  wire logic              tmr_reload_in,
  // processor first fetch
  input  wire logic              first_fetch_in,
  // error message from host memory controller
  input  wire logic              err_msg_valid_in,
  input  wire shs_err_cls_t      err_msg_cls_in,
  // function disable and raw function signals
  input  wire logic [6:0]        func_disable_in,
  input  wire shs_func_t         func_raw_in,
  // intrusion
  input  wire logic              intruder_n_in,
  input  wire logic              intr_sel_in,
  input  wire logic              intr_clear_in,
  // outputs
  output var  logic              sys_mgmt_irq_n_out,
  output var  logic              nmi_out,
  output var  logic              system_error_n_out,
  output var  logic              lockup_timer_irq_out,
  output var  logic              sys_reset_out,
  output var  logic              first_expired_out,
  output var  logic              intr_latched_out,
  output var  logic [15:0]       tmr_count_out,
  output var  shs_func_t         func_gated_out
);

  logic [15:0] cnt_q;
  logic        first_q;
  logic        expire;
  logic [3:0]  rst_cnt_q;
  logic        fetch_seen_q;
  logic [31:0] fetch_cnt_q;
  logic        fetch_fail;
  logic        sync1_q;
  logic        sync2_q;
  logic        intr_q;
  logic        intr_rise;

  assign expire     = tmr_enable_in && !tmr_reload_in && (cnt_q == 16'h0000);
  assign fetch_fail = !fetch_seen_q && !first_fetch_in && (fetch_cnt_q == FETCH_WAIT - 1);

  // lockup timer counts down and restarts from the reload value
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_q <= SHS_TMR_RELOAD_RST;
    else if (tmr_reload_in || expire || !tmr_enable_in)
      cnt_q <= tmr_reload_val_in;
    else
      cnt_q <= cnt_q - 16'h0001;
  end

  // first expiry state, cleared by reload
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      first_q <= 1'b0;
    else if (tmr_reload_in)
      first_q <= 1'b0;
    else if (expire)
      first_q <= !first_q; // second expiry clears it, rearming as the reset pulse starts
  end

  // first fetch watch, fires again every FETCH_WAIT cycles until the first fetch is seen
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fetch_seen_q <= 1'b0;
      fetch_cnt_q  <= 32'h0000_0000;
    end
    else if (first_fetch_in)
      fetch_seen_q <= 1'b1;
    else if (!fetch_seen_q)
      fetch_cnt_q <= fetch_fail ? 32'h0000_0000 : fetch_cnt_q + 32'h0000_0001;
  end

  // reset pulse stretcher for second expiry or missing fetch
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_cnt_q <= 4'h0;
    else if ((expire && first_q) || fetch_fail)
      rst_cnt_q <= SHS_RST_PULSE;
    else if (rst_cnt_q != 4'h0)
      rst_cnt_q <= rst_cnt_q - 4'h1;
  end

  // intrusion pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= !intruder_n_in;
      sync2_q <= sync1_q;
    end
  end

  assign intr_rise = sync2_q && !intr_q;

  // sticky intrusion flag; a live intrusion beats the clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      intr_q <= 1'b0;
    else if (sync2_q)
      intr_q <= 1'b1;
    else if (intr_clear_in)
      intr_q <= 1'b0;
  end

  // interrupt outputs, one-cycle pulses, all registered
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sys_mgmt_irq_n_out   <= 1'b1;
      nmi_out              <= 1'b0;
      system_error_n_out   <= 1'b1;
      lockup_timer_irq_out <= 1'b0;
    end
    else
    begin
      sys_mgmt_irq_n_out <= !((expire && !first_q)
                           || (err_msg_valid_in && err_msg_cls_in == SHS_ERR_SMI)
                           || (intr_rise && intr_sel_in == SHS_INTR_TO_SMI));
      nmi_out            <= err_msg_valid_in && err_msg_cls_in == SHS_ERR_NMI;
      system_error_n_out <= !(err_msg_valid_in && err_msg_cls_in == SHS_ERR_SYSTEM_ERROR_N);
      lockup_timer_irq_out <= (err_msg_valid_in && err_msg_cls_in == SHS_ERR_TMR)
                           || (intr_rise && intr_sel_in != SHS_INTR_TO_SMI);
    end
  end

  // status and gated function signals
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sys_reset_out     <= 1'b0;
      first_expired_out <= 1'b0;
      intr_latched_out  <= 1'b0;
      tmr_count_out     <= SHS_TMR_RELOAD_RST;
      func_gated_out    <= '0;
    end
    else
    begin
      sys_reset_out            <= (expire && first_q) || fetch_fail || (rst_cnt_q > 4'h1);
      first_expired_out        <= first_q;
      intr_latched_out         <= intr_q;
      tmr_count_out            <= cnt_q;
      func_gated_out.decode    <= func_raw_in.decode & ~func_disable_in;
      func_gated_out.event_irq <= func_raw_in.event_irq & ~func_disable_in;
    end
  end

  // checks
  a_first_expiry_smi: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (expire && !first_q) |=> !sys_mgmt_irq_n_out) else $error("first expiry gave no smi");
  a_second_expiry_rst: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (expire && first_q) |=> sys_reset_out [*8]) else $error("second expiry gave no reset");
  a_fetch_reboot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fetch_fail |=> sys_reset_out) else $error("missing fetch gave no reboot");
  a_err_nmi_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (err_msg_valid_in && err_msg_cls_in == SHS_ERR_NMI) |=> nmi_out && system_error_n_out)
    else $error("nmi message misrouted");
  a_err_system_error_n_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (err_msg_valid_in && err_msg_cls_in == SHS_ERR_SYSTEM_ERROR_N) |=> !system_error_n_out && !nmi_out)
    else $error("system_error_n message misrouted");
  a_disable_decode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(func_disable_in[SHS_F_LAN]) |-> !func_gated_out.decode[SHS_F_LAN]) else $error("disabled decode");
  a_disable_event: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(func_disable_in[SHS_F_SMB]) |-> !func_gated_out.event_irq[SHS_F_SMB]) else $error("disabled event");
  a_intr_route_tmr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (intr_rise && intr_sel_in) |=> lockup_timer_irq_out) else $error("intrusion not routed");
  a_reload_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tmr_reload_in |=> !first_q ##1 !first_expired_out) else $error("reload kept first expiry");
  a_intr_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sync2_q || (intr_q && !intr_clear_in)) |=> intr_q) else $error("intrusion flag lost");
  a_intr_route_smi: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (intr_rise && intr_sel_in == SHS_INTR_TO_SMI) |=> !sys_mgmt_irq_n_out) else $error("intrusion smi missing");
  a_err_tmr_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (err_msg_valid_in && err_msg_cls_in == SHS_ERR_TMR) |=> lockup_timer_irq_out && !nmi_out)
    else $error("timer class message misrouted");
  a_err_smi_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (err_msg_valid_in && err_msg_cls_in == SHS_ERR_SMI) |=> !sys_mgmt_irq_n_out) else $error("smi message misrouted");

  c_first_expiry: cover property (@(posedge clk_in) disable iff (!rst_n_in) expire && !first_q);
  c_second_expiry: cover property (@(posedge clk_in) disable iff (!rst_n_in) expire && first_q);
  c_intrusion: cover property (@(posedge clk_in) disable iff (!rst_n_in) intr_rise);
  c_err_msg: cover property (@(posedge clk_in) disable iff (!rst_n_in) err_msg_valid_in);
  c_fetch_fail: cover property (@(posedge clk_in) disable iff (!rst_n_in) fetch_fail);

endmodule // shs_supervisor
`default_nettype wire

// File: verification/shs_host_model.sv
// host processor and memory controller model: first fetch and error messages
`timescale 1ns/1ps
`default_nettype none
module shs_host_model
  import shs_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         fetch_req_in,
  input  wire logic         err_req_in,
  input  wire shs_err_cls_t err_cls_req_in,
  output var  logic         first_fetch_out,
  output var  logic         err_valid_out,
  output var  shs_err_cls_t err_cls_out
);
  // one process drives every output; on the falling edge an idle class code toggles so it is never trusted
  initial
  begin
    first_fetch_out = 1'b0;
    err_valid_out   = 1'b0;
    err_cls_out     = SHS_ERR_SMI;
    forever
    begin
      @(negedge clk_in);
      first_fetch_out <= fetch_req_in;
      err_valid_out   <= err_req_in;
      err_cls_out     <= err_req_in ? err_cls_req_in : shs_err_cls_t'(~err_cls_out);
    end
  end
endmodule // shs_host_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking testbench for the system health supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import shs_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, tmr_enable_in = 1'b0, tmr_reload_in = 1'b0;
  logic fetch_req = 1'b0, err_req = 1'b0, intruder_n_in = 1'b1, intr_sel_in = 1'b0, intr_clear_in = 1'b0;
  logic [6:0] func_disable_in = 7'h00;
  shs_func_t func_raw_in = 14'h3ADC;
  shs_err_cls_t err_cls_req = SHS_ERR_SMI, err_cls;
  logic smi_n, nmi, system_error_n_n, tirq, sys_rst, first_exp, latched, first_fetch, err_valid;
  logic [15:0] count;
  shs_func_t gated;
  logic [4:0] obs;
  int miscompares = 0, n_tests = 0, nrst = 0;
  // rows: error class, expected pulses, disable pattern
  shs_err_cls_t cls_r [4] = '{SHS_ERR_SMI, SHS_ERR_NMI, SHS_ERR_SYSTEM_ERROR_N, SHS_ERR_TMR};
  logic [4:0] exp_r [4] = '{5'h10, 5'h08, 5'h04, 5'h02};
  logic [6:0] dis_r [4] = '{7'h00, 7'h7F, 7'h55, 7'h2A};
  always #2.5 clk_in = ~clk_in;
  shs_host_model u_host (.clk_in(clk_in), .fetch_req_in(fetch_req), .err_req_in(err_req),
    .err_cls_req_in(err_cls_req), .first_fetch_out(first_fetch), .err_valid_out(err_valid), .err_cls_out(err_cls));
  shs_supervisor #(.FETCH_WAIT(16)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .tmr_enable_in(tmr_enable_in),
    .tmr_reload_val_in(16'h0004), .tmr_reload_in(tmr_reload_in), .first_fetch_in(first_fetch),
    .err_msg_valid_in(err_valid), .err_msg_cls_in(err_cls), .func_disable_in(func_disable_in),
    .func_raw_in(func_raw_in), .intruder_n_in(intruder_n_in), .intr_sel_in(intr_sel_in),
    .intr_clear_in(intr_clear_in), .sys_mgmt_irq_n_out(smi_n), .nmi_out(nmi), .system_error_n_out(system_error_n_n),
    .lockup_timer_irq_out(tirq), .sys_reset_out(sys_rst), .first_expired_out(first_exp),
    .intr_latched_out(latched), .tmr_count_out(count), .func_gated_out(gated));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // collect active pulses over n falling edges
  task automatic watch(input int n);
    obs = 5'h00;
    repeat (n)
    begin
      @(negedge clk_in);
      obs |= {~smi_n, nmi, ~system_error_n_n, tirq, sys_rst};
      nrst += int'(sys_rst);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_in);
    check(16'({smi_n, sys_rst, latched}), 16'h0004);
    check(count, 16'hFFFF);
    rst_n_in <= 1'b1;
    watch(14);
    check(16'(obs[0]), 16'h0000);
    watch(10);
    check(16'(obs[0]), 16'h0001);
    fetch_req <= 1'b1;
    watch(20);
    check(16'(nrst), 16'h000F);
    for (int i = 0; i < 4; i++)
    begin
      err_cls_req <= cls_r[i];
      err_req <= 1'b1;
      func_disable_in <= dis_r[i];
      @(negedge clk_in);
      err_req <= 1'b0;
      watch(5);
      check(16'(obs), 16'(exp_r[i]));
      check(16'(gated), 16'(func_raw_in & {~dis_r[i], ~dis_r[i]}));
    end
    // software reload pulses between expiries
    tmr_enable_in <= 1'b1;
    tmr_reload_in <= 1'b1;
    @(negedge clk_in);
    tmr_reload_in <= 1'b0;
    watch(8);
    check(16'(obs), 16'h0010);
    check(16'(first_exp), 16'h0001);
    check(count, 16'h0002);
    tmr_reload_in <= 1'b1;
    @(negedge clk_in);
    tmr_reload_in <= 1'b0;
    watch(8);
    check(16'(obs), 16'h0010);
    watch(8);
    check(16'(obs[0]), 16'h0001);
    tmr_enable_in <= 1'b0;
    watch(20);
    intruder_n_in <= 1'b0;
    watch(6);
    check(16'(obs), 16'h0010);
    check(16'(latched), 16'h0001);
    intr_clear_in <= 1'b1;
    @(negedge clk_in);
    intr_clear_in <= 1'b0;
    intruder_n_in <= 1'b1;
    watch(4);
    check(16'(latched), 16'h0001);
    intr_clear_in <= 1'b1;
    @(negedge clk_in);
    intr_clear_in <= 1'b0;
    intr_sel_in <= 1'b1;
    watch(3);
    check(16'(latched), 16'h0000);
    intruder_n_in <= 1'b0;
    watch(6);
    check(16'(obs), 16'h0002);
    complete_run();
  end
  // watchdog well beyond the roughly 140 cycles the tests need
  initial
  begin
    #10000;
    miscompares++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
